// File: rtl/mid_pkg.sv
// Package for the instruction decoder: field layout, group codes, cycle timing.
// Assumes a single 125 MHz system clock and an asynchronous active-high reset.
package mid_pkg;
  // Instruction word and operand field layout
  localparam int IW_W = 14;
  localparam int FA_LSB = 0;
  localparam int FA_W = 7;
  localparam int DST_POS = 7;
  localparam int BIT_LSB = 7;
  localparam int BIT_W = 3;
  localparam int K8_W = 8;
  localparam int K11_W = 11;
  localparam int OPC_LSB = 12;
  // Top two opcode bits select the group
  localparam logic [1:0] OPC_BYTE = 2'h0;
  localparam logic [1:0] OPC_BIT = 2'h1;
  localparam logic [1:0] OPC_GOTO_CALL = 2'h2;
  localparam logic [1:0] OPC_LIT = 2'h3;
  // Oscillator periods per instruction cycle
  localparam int OSC_PER_CYC = 4;
  localparam int PH_W = 2;
  localparam logic [PH_W-1:0] PH_LAST = 2'h3;
  // Reset values
  localparam logic [IW_W-1:0] IW_RST = 14'h0000;

  // Instruction group
  typedef enum logic [1:0] {
    MID_GRP_BYTE = 2'b00,
    MID_GRP_BIT = 2'b01,
    MID_GRP_LIT = 2'b10
  } mid_grp_e;
endpackage

// File: rtl/mid_phase_div.sv
// Quarter-cycle divider: four oscillator periods make one instruction cycle.
// Assumes i_osc_en is a one-cycle oscillator tick on the system clock.
module mid_phase_div
  import mid_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Oscillator tick
  input wire logic i_osc_en,
  // Phase outputs
  output logic [mid_pkg::PH_W-1:0] o_phase,
  output logic o_cyc_end
);
  typedef struct packed {
    logic [PH_W-1:0] ph;
  } mid_div_s;

  mid_div_s st_r;
  mid_div_s st_nxt;

  // Advance the phase on every oscillator tick
  always_comb begin
    st_nxt = st_r;
    if (i_osc_en) begin
      st_nxt.ph = st_r.ph + 2'h1;
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_phase = st_r.ph;
  // Last quarter of the cycle with a tick ends the instruction cycle
  assign o_cyc_end = i_osc_en && (st_r.ph == PH_LAST);

  chk_phase_wrap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_cyc_end |=> (o_phase == '0))
    else $error("phase did not wrap after cycle end");
endmodule

// File: rtl/mid_decoder.sv
// Instruction decoder: splits 14-bit words into fields, groups and cycle timing.
// Assumes program memory supplies i_instr with i_instr_vld, and the datapath
// reports i_skip_taken for a true conditional test during execution.
module mid_decoder
  import mid_pkg::*;
(
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Oscillator tick, one cycle wide
  input wire logic i_osc_en,
  // Instruction from program memory
  input wire logic [mid_pkg::IW_W-1:0] i_instr,
  input wire logic i_instr_vld,
  // Datapath reports a true conditional test
  input wire logic i_skip_taken,
  // Decoded fields
  output logic [1:0] o_group,
  output logic [mid_pkg::FA_W-1:0] o_faddr,
  output logic o_dest_file,
  output logic [7:0] o_bit_mask,
  output logic [mid_pkg::K11_W-1:0] o_literal,
  output logic o_lit_long,
  output logic o_pc_change,
  // Cycle control
  output logic o_exec,
  output logic o_nop_cycle,
  output logic o_cyc_end,
  output logic [mid_pkg::PH_W-1:0] o_phase
);
  import mid_pkg::*;

  typedef struct packed {
    logic [1:0] grp;
    logic [FA_W-1:0] fa;
    logic dst;
    logic [7:0] mask;
    logic [K11_W-1:0] lit;
    logic lng;
    logic pcc;
    logic exec;
    logic nop;
    logic flush;
  } mid_dec_s;

  mid_dec_s st_r;
  mid_dec_s st_nxt;
  logic cyc_end;
  logic [PH_W-1:0] phase;
  logic [BIT_W-1:0] bsel;
  logic [7:0] bmask;
  logic [1:0] opc;
  logic pc_alter;

  // Divider for the four-period instruction cycle
  mid_phase_div u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_osc_en(i_osc_en),
    .o_phase(phase),
    .o_cyc_end(cyc_end)
  );

  assign bsel = i_instr[BIT_LSB +: BIT_W];
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_mask
      assign bmask[gi] = (bsel == BIT_W'(gi));
    end
  endgenerate

  assign opc = i_instr[OPC_LSB +: 2];

  // Words that reload the program counter: goto/call, return group, pc writes
  always_comb begin
    pc_alter = 1'b0;
    if (opc == OPC_GOTO_CALL) begin
      pc_alter = 1'b1;
    end else if (opc == OPC_BYTE && i_instr[DST_POS] && i_instr[FA_W-1:0] == 7'h02) begin
      pc_alter = 1'b1;
    end else if (opc == OPC_LIT && i_instr[11:10] == 2'h1) begin
      pc_alter = 1'b1;
    end else if (i_instr[13:8] == 6'h00 && i_instr[7] == 1'b0 &&
                 (i_instr[3:0] == 4'h8 || i_instr[3:0] == 4'h9)) begin
      pc_alter = 1'b1;
    end
  end

  // Decode at each cycle end; flush cycle runs as a no-operation
  always_comb begin
    st_nxt = st_r;
    if (cyc_end) begin
      st_nxt.exec = 1'b0;
      st_nxt.nop = 1'b0;
      if (st_r.exec && (st_r.pcc || i_skip_taken)) begin
        st_nxt.nop = 1'b1;
      end else if (i_instr_vld) begin
        st_nxt.exec = 1'b1;
        st_nxt.fa = i_instr[FA_LSB +: FA_W];
        st_nxt.pcc = pc_alter;
        st_nxt.dst = 1'b0;
        st_nxt.mask = 8'h00;
        st_nxt.lng = 1'b0;
        st_nxt.lit = '0;
        case (opc)
          OPC_BYTE: begin
            st_nxt.grp = MID_GRP_BYTE;
            st_nxt.dst = i_instr[DST_POS];
          end
          OPC_BIT: begin
            st_nxt.grp = MID_GRP_BIT;
            st_nxt.mask = bmask;
          end
          OPC_GOTO_CALL: begin
            st_nxt.grp = MID_GRP_LIT;
            st_nxt.lit = i_instr[K11_W-1:0];
            st_nxt.lng = 1'b1;
            st_nxt.fa = '0;
          end
          default: begin
            st_nxt.grp = MID_GRP_LIT;
            st_nxt.lit = {3'h0, i_instr[K8_W-1:0]};
            st_nxt.fa = '0;
          end
        endcase
      end
    end
  end

  // State register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_faddr = st_r.fa;
  assign o_group = st_r.grp;
  assign o_dest_file = st_r.dst;
  assign o_bit_mask = st_r.mask;
  assign o_literal = st_r.lit;
  assign o_lit_long = st_r.lng;
  assign o_pc_change = st_r.pcc;
  assign o_exec = st_r.exec;
  assign o_nop_cycle = st_r.nop;
  assign o_cyc_end = cyc_end;
  assign o_phase = phase;

  // Execute then forced no-operation
  sequence s_branch_end;
    o_exec && o_pc_change && cyc_end;
  endsequence
  chk_branch_nop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_branch_end |=> o_nop_cycle && !o_exec)
    else $error("branch not followed by no-operation cycle");
  chk_nop_single: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_nop_cycle && cyc_end |=> !o_nop_cycle)
    else $error("no-operation lasted over one cycle");
  chk_cycle_four: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cyc_end |-> phase == PH_LAST && i_osc_en)
    else $error("cycle ended off the last phase");
  chk_mask_onehot: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_exec && o_group == MID_GRP_BIT |-> $onehot(o_bit_mask))
    else $error("bit mask not one-hot");
  chk_dest_field: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cyc_end && i_instr_vld && !o_nop_cycle && !(o_exec && (o_pc_change || i_skip_taken))
    && opc == OPC_BYTE |=> o_dest_file == $past(i_instr[DST_POS]))
    else $error("destination select wrong");
  chk_group_legal: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_exec |-> o_group != 2'b11)
    else $error("illegal group");
  chk_lit_width: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_exec && o_group == MID_GRP_LIT && !o_lit_long |-> o_literal[10:8] == 3'h0)
    else $error("short literal wider than eight bits");
  chk_fa_zero_lit: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_exec && o_group == MID_GRP_LIT |-> o_faddr == '0)
    else $error("file address leaked on literal word");
  // true test adds a no-operation cycle
  sequence s_skip_end;
    o_exec && i_skip_taken && cyc_end;
  endsequence
  chk_skip_nop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_skip_end |=> o_nop_cycle && !o_exec)
    else $error("true test not followed by no-operation cycle");
  // plain word executes in the next cycle
  sequence s_word_taken;
    cyc_end && i_instr_vld && !(o_exec && (o_pc_change || i_skip_taken));
  endsequence
  chk_word_exec: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_word_taken |=> o_exec && !o_nop_cycle)
    else $error("offered word did not execute");
  // at least four clocks between cycle ends
  chk_cycle_gap: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    cyc_end |=> !cyc_end [*3])
    else $error("instruction cycle shorter than four ticks");
  // decoded outputs stand for the whole cycle
  chk_hold_cycle: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !cyc_end |=> $stable(st_r))
    else $error("decoded outputs changed inside a cycle");
  // mask stays clear outside bit words
  chk_mask_other: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_exec && o_group != MID_GRP_BIT |-> o_bit_mask == 8'h00)
    else $error("bit mask set on a non-bit word");
  // destination select only on byte words
  chk_dest_byte: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    o_exec && o_group != MID_GRP_BYTE |-> !o_dest_file)
    else $error("destination set on a non-byte word");
endmodule

// File: bench/mid_pmem_model.sv
// Program memory and datapath stand-in facing the decoder.
// Assumes the bench loads word, valid and skip request between edges.
module mid_pmem_model (
  // Decoder status
  input wire logic i_exec,
  input wire logic i_cyc_end,
  // Toward the decoder
  output logic [mid_pkg::IW_W-1:0] o_instr,
  output logic o_vld,
  output logic o_skip
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [mid_pkg::IW_W-1:0] word_r = 14'h0000;
  logic vld_r = 1'b0;
  logic skip_r = 1'b0;
  // A released bus shows the inverse of the last word
  assign o_instr = vld_r ? word_r : ~word_r;
  assign o_vld = vld_r;
  // A true test is reported only at the end of an executing cycle
  assign o_skip = skip_r & i_exec & i_cyc_end;
endmodule

// File: bench/mcu_instruction_decoder_tb.sv
// Self-checking bench for the instruction decoder.
// Assumes the oscillator tick stays high, so one cycle is four clocks,
// except in the slow-tick test, where it ticks on every second clock.
module mcu_instruction_decoder_tb import mid_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic osc = 1'b1;
  logic [IW_W-1:0] instr;
  logic vld, skip, dest, long_k, pcc, exec, nop, cend;
  logic [1:0] grp, phase;
  logic [6:0] fa;
  logic [7:0] mask;
  logic [10:0] lit;
  int fails = 0;
  int cmp_count = 0;
  // Free-running system clock
  always #4 clk = ~clk;
  mid_decoder dut_u (.i_clk_sys(clk), .i_rst(rst), .i_osc_en(osc), .i_instr(instr),
    .i_instr_vld(vld), .i_skip_taken(skip), .o_group(grp), .o_faddr(fa),
    .o_dest_file(dest), .o_bit_mask(mask), .o_literal(lit), .o_lit_long(long_k),
    .o_pc_change(pcc), .o_exec(exec), .o_nop_cycle(nop), .o_cyc_end(cend), .o_phase(phase));
  mid_pmem_model pm_u (.i_exec(exec), .i_cyc_end(cend), .o_instr(instr), .o_vld(vld),
    .o_skip(skip));
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // Offer a word and stop just after the edge that decodes it
  task automatic run(input logic [13:0] w);
    int n;
    n = 0;
    pm_u.word_r = w;
    pm_u.vld_r = 1'b1;
    while (cend !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 8) fails++;
    @(posedge clk);
    #1;
  endtask
  task automatic t_byte();
    run(14'h0885);
    chk(11'(grp), 11'(MID_GRP_BYTE));
    chk(11'(fa), 11'h005);
    chk(11'({exec, dest}), 11'h003);
    run(14'h00FF);
    chk(11'(fa), 11'h07F);
    run(14'h0005);
    chk(11'(dest), 11'h000);
    $display("test byte done");
  endtask
  task automatic t_bit();
    for (int b = 0; b < 8; b++) begin
      run(14'h107F | 14'(b << 7));
      chk(11'(grp), 11'(MID_GRP_BIT));
      chk(11'(mask), 11'(8'h01 << b));
    end
    $display("test bit done");
  endtask
  task automatic t_lit();
    run(14'h305A);
    chk(11'({long_k, grp}), 11'(MID_GRP_LIT));
    chk(lit, 11'h05A);
    run(14'h335A);
    chk(lit, 11'h05A);
    $display("test literal done");
  endtask
  task automatic t_branch();
    run(14'h2ABC);
    chk(lit, 11'h2BC);
    chk(11'({pcc, long_k}), 11'h003);
    run(14'h0885);
    chk(11'({nop, exec}), 11'h002);
    run(14'h0885);
    chk(11'({nop, exec}), 11'h001);
    pm_u.skip_r = 1'b1;
    run(14'h0005);
    pm_u.skip_r = 1'b0;
    chk(11'({nop, exec}), 11'h002);
    $display("test branch done");
  endtask
  task automatic t_phase();
    int n;
    n = 1;
    chk(11'(phase), 11'(PH_LAST));
    @(posedge clk);
    #1;
    while (cend !== 1'b1 && n < 9) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(11'(n), 11'(OSC_PER_CYC));
    $display("test phase done");
  endtask
  // Tick on every second clock: one instruction cycle should span eight clocks
  task automatic t_slow();
    int n;
    n = 0;
    @(posedge clk);
    #1;
    osc = 1'b0;
    while ((n < 2 || phase !== 2'h0) && n < 20) begin
      @(posedge clk);
      #1;
      n++;
      if (n < 2 || phase !== 2'h0) osc = ~osc;
    end
    osc = 1'b1;
    chk(11'(n), 11'(2 * OSC_PER_CYC));
    $display("test slow tick done");
  endtask
  // Reset in mid-run, first word after release, then an idle cycle
  task automatic t_reset();
    int n;
    n = 0;
    rst = 1'b1;
    @(posedge clk);
    #1;
    chk(11'({exec, nop, grp, phase}), 11'h000);
    rst = 1'b0;
    while (cend !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(11'(n), 11'(OSC_PER_CYC - 1));
    @(posedge clk);
    #1;
    chk(11'({nop, exec}), 11'h001);
    pm_u.vld_r = 1'b0;
    n = 0;
    while (cend !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    @(posedge clk);
    #1;
    chk(11'({nop, exec}), 11'h000);
    $display("test reset done");
  endtask
  task automatic final_report();
    $display("compares %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1;
    chk(11'({exec, grp, phase}), 11'h000);
    rst = 1'b0;
    t_byte();
    t_bit();
    t_lit();
    t_branch();
    while (cend !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    t_phase();
    t_slow();
    t_reset();
    final_report();
  end
  // Watchdog against a hang
  initial begin
    #20000;
    fails++;
    final_report();
  end
endmodule
